// File: rcac_ctl_model.sv
/*
 * Model of the external process controller that drives the remote zero and
 * span commands. Assumes cal_busy comes from the block, synchronous to clk.
 */
module rcac_ctl_model (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Scenario control
	input wire logic go,
	input wire logic span,
	input wire logic [7:0] hold,
	// Block side
	input wire logic cal_busy,
	output logic remote_zero,
	output logic remote_span
);
	timeunit 1ns;
	timeprecision 1ps;
	logic cmd_q;
	logic sel_q;
	assign remote_zero = cmd_q && !sel_q;
	assign remote_span = cmd_q && sel_q;
	initial begin
		cmd_q = 1'b0;
		sel_q = 1'b0;
		forever begin
			@(posedge clk);
			if (go && !srst) begin
				sel_q <= span;
				if (hold == 8'h00) begin
					// Command only while the contact is open
					while (cal_busy) @(posedge clk);
					cmd_q <= 1'b1;
					do @(posedge clk); while (!cal_busy);
					cmd_q <= 1'b0;
				end else begin
					// Deliberate hold whatever the contact shows
					cmd_q <= 1'b1;
					repeat (hold) @(posedge clk);
					cmd_q <= 1'b0;
				end
			end
		end
	end
endmodule // rcac_ctl_model

// File: rcac_pkg.sv
/*
 * Package for the remote calibration and alarm control block: register map,
 * field positions, reset values, range codes and state encodings.
 * Assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock.
 */
package rcac_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
	localparam logic [7:0] ADDR_AL1_CFG = 8'h10;
	localparam logic [7:0] ADDR_AL2_CFG = 8'h14;
	localparam logic [7:0] ADDR_CONC = 8'h18;

	// Control register fields
	localparam int CTRL_CAL_DONE = 0;
	localparam int CTRL_RANGE_LO = 4;
	localparam int CTRL_KEY_PWR = 8;
	localparam int CTRL_KEY_OTHER = 9;

	// Alarm config fields: threshold in [15:0], mode bits above
	localparam int CFG_HIGH = 16;
	localparam int CFG_FAILSAFE = 17;
	localparam int CFG_LATCH = 18;
	localparam int CFG_DEFEAT = 19;
	localparam int CFG_THR_W = 16;

	// Alarm config reset: defeated, high, not failsafe, not latching
	localparam logic [31:0] CFG_RESET = 32'h0009_0000;

	// Interrupt bits
	localparam int IRQ_CAL_START = 0;
	localparam int IRQ_CAL_END = 1;
	localparam int IRQ_REJECT = 2;
	localparam int IRQ_AL1 = 3;
	localparam int IRQ_AL2 = 4;
	localparam int IRQ_SYS = 5;
	localparam int IRQ_W = 6;

	// Range codes, ascending
	localparam logic [1:0] RANGE_LOW = 2'h0;
	localparam logic [1:0] RANGE_MED = 2'h1;
	localparam logic [1:0] RANGE_HIGH = 2'h2;
	localparam logic [1:0] RANGE_AIR = 2'h3;

	// Range ID output levels: volts in 1/100 V, current in 1/10 mA
	localparam logic [7:0] VID_LOW = 8'h19;
	localparam logic [7:0] VID_MED = 8'h32;
	localparam logic [7:0] VID_HIGH = 8'h4B;
	localparam logic [7:0] VID_AIR = 8'h64;
	localparam logic [7:0] IID_LOW = 8'h50;
	localparam logic [7:0] IID_MED = 8'h78;
	localparam logic [7:0] IID_HIGH = 8'hA0;
	localparam logic [7:0] IID_AIR = 8'hC8;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_ZERO = 2'b01,
		CAL_SPAN = 2'b10
	} rcac_cal_t;

	typedef enum logic [1:0] {
		SYS_OK = 2'b00,
		SYS_LATCHED = 2'b01,
		SYS_PWR_OFF = 2'b10,
		SYS_WAIT_KEY = 2'b11
	} rcac_sys_t;

endpackage

// File: rcac_tb.sv
/*
 * Self-checking bench for rcac_top: AXI4-Lite master tasks, read-data
 * queue with a monitor, controller model on the calibration inputs.
 */
module testbench
	import rcac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, srst, go, span, supply_fault, self_test_fail;
	logic [7:0] s_axi_awaddr, s_axi_araddr, hold, range_id_volt, range_id_curr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic remote_zero, remote_span, cal_busy, al1_relay, al2_relay, sys_relay, irq;
	logic [33:0] rq [$];
	logic [15:0] rt [4];
	logic [15:0] thr;
	int bad_count, check_count;
	rcac_top dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .remote_zero, .remote_span, .cal_busy, .supply_fault, .self_test_fail,
		.al1_relay, .al2_relay, .sys_relay, .range_id_volt, .range_id_curr, .irq);
	rcac_ctl_model ctl (.clk, .srst, .go, .span, .hold, .cal_busy, .remote_zero, .remote_span);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task chk(input logic [33:0] e, input logic [33:0] a);
		check_count++;
		if (a !== e) begin
			bad_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 100);
		if (!s_axi_bvalid) bad_count++;
		chk(34'(er), 34'(s_axi_bresp));
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a, input logic [33:0] e);
		int n;
		n = 0;
		rq.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 100);
		if (!s_axi_rvalid) bad_count++;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask
	// Read results are judged here, oldest note first
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
			chk(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		end
	end
	task wbusy(input logic v);
		int n;
		n = 0;
		while (cal_busy !== v && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(34'(v), 34'(cal_busy));
	endtask
	task cmd(input logic s, input logic [7:0] h);
		go <= 1'b1;
		span <= s;
		hold <= h;
		@(posedge clk);
		go <= 1'b0;
	endtask
	task al(input logic [31:0] c, input logic [15:0] v, input logic e);
		wr(ADDR_AL1_CFG, c);
		wr(ADDR_CONC, {16'h0000, v});
		cyc(4);
		chk(34'(e), 34'(al1_relay));
	endtask
	task conclude;
		if (rq.size() != 0) bad_count++;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		srst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{go, span, supply_fault, self_test_fail} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		hold = '0;
		bad_count = 0;
		check_count = 0;
		rt = '{{VID_LOW, IID_LOW}, {VID_MED, IID_MED}, {VID_HIGH, IID_HIGH}, {VID_AIR, IID_AIR}};
		void'($urandom(32'h8e93));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		cyc(2);
		chk(34'(1'b1), 34'(sys_relay));
		chk(34'(rt[0]), 34'({range_id_volt, range_id_curr}));
		rd(ADDR_AL1_CFG, {RESP_OKAY, CFG_RESET});
		rd(8'h40, {RESP_SLVERR, 32'h0000_0000});
		wr(ADDR_STATUS, 32'h0000_00FF, RESP_SLVERR);
		$display("test registers done");
		wr(ADDR_IRQ_STAT, 32'h0000_003F);
		wr(ADDR_IRQ_MASK, 32'h0000_0001);
		cmd(1'b0, 8'h00);
		wbusy(1'b1);
		cyc(3);
		chk(34'(1'b1), 34'(irq));
		rd(ADDR_STATUS, {RESP_OKAY, 32'h0000_0006});
		rd(ADDR_IRQ_STAT, {RESP_OKAY, 32'h0000_0001});
		wr(ADDR_IRQ_STAT, 32'h0000_0001);
		cyc(2);
		chk(34'(1'b0), 34'(irq));
		// Span request while busy must be dropped
		cmd(1'b1, 8'h04);
		cyc(8);
		rd(ADDR_STATUS, {RESP_OKAY, 32'h0000_0006});
		rd(ADDR_IRQ_STAT, {RESP_OKAY, 32'h0000_0004});
		chk(34'(1'b0), 34'(irq));
		wr(ADDR_CTRL, 32'h0000_0001);
		wbusy(1'b0);
		cyc(6);
		chk(34'(1'b0), 34'(cal_busy));
		cmd(1'b1, 8'h00);
		wbusy(1'b1);
		rd(ADDR_STATUS, {RESP_OKAY, 32'h0000_000A});
		wr(ADDR_CTRL, 32'h0000_0001);
		wbusy(1'b0);
		// Command held past completion restarts
		cmd(1'b0, 8'h3C);
		wbusy(1'b1);
		wr(ADDR_CTRL, 32'h0000_0001);
		cyc(3);
		chk(34'(1'b1), 34'(cal_busy));
		rd(ADDR_STATUS, {RESP_OKAY, 32'h0000_0006});
		cyc(70);
		wr(ADDR_CTRL, 32'h0000_0001);
		wbusy(1'b0);
		$display("test calibration done");
		al(32'h0001_0064, 16'd150, 1'b1);
		al(32'h0001_0064, 16'd50, 1'b0);
		al(32'h0000_0064, 16'd50, 1'b1);
		al(32'h0002_0064, 16'd150, 1'b1);
		al(32'h0006_0064, 16'd50, 1'b0);
		al(32'h0006_0064, 16'd150, 1'b0);
		al(32'h0009_0064, 16'd150, 1'b0);
		al(32'h000A_0064, 16'd150, 1'b1);
		thr = 16'($urandom_range(60000, 1000));
		wr(ADDR_AL2_CFG, {16'h0001, thr});
		wr(ADDR_CONC, {16'h0000, thr + 16'h0001});
		cyc(4);
		chk(34'(1'b1), 34'(al2_relay));
		wr(ADDR_CONC, {16'h0000, thr});
		cyc(4);
		chk(34'(1'b0), 34'(al2_relay));
		$display("test threshold alarms done");
		for (int i = 0; i < 2; i++) begin
			supply_fault <= (i == 0);
			self_test_fail <= (i == 1);
			cyc(2);
			{supply_fault, self_test_fail} <= 2'b00;
			cyc(3);
			chk(34'(1'b0), 34'(sys_relay));
			wr(ADDR_CTRL, 32'h0000_0200);
			cyc(3);
			chk(34'(1'b0), 34'(sys_relay));
			wr(ADDR_CTRL, 32'h0000_0100);
			wr(ADDR_CTRL, 32'h0000_0100);
			wr(ADDR_CTRL, 32'h0000_0200);
			cyc(3);
			chk(34'(1'b1), 34'(sys_relay));
		end
		$display("test system alarm done");
		for (int r = 0; r < 4; r++) begin
			wr(ADDR_CTRL, 32'(r) << CTRL_RANGE_LO);
			cyc(3);
			chk(34'(rt[r]), 34'({range_id_volt, range_id_curr}));
		end
		$display("test range id done");
		conclude();
	end
	initial begin
		#100000;
		bad_count++;
		conclude();
	end
endmodule // testbench

// File: rcac_top.sv
/*
 * Remote calibration handshake, threshold and system alarm relays,
 * range identification outputs, AXI4-Lite register slave and interrupt.
 * Assumes remote command inputs and monitor inputs are synchronous to clk;
 * the calibration engine reports completion by a control register write.
 */
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
// Overview of operation
// [RULE1] A high remote zero input starts zero calibration, a high span input starts span.
// [RULE2] The busy contact is closed exactly while a zero or span calibration runs.
// [RULE3] While the busy contact is open the remote command inputs are sampled each cycle.
// [RULE4] Requests arriving during a calibration are dropped and never remembered.
// [RULE5] The controller checks busy open, asserts a command, and releases it once busy closes.
// [RULE6] A command still high when calibration ends restarts that calibration at once.
// [RULE7] For full calibration the controller waits for busy to reopen after zero before span.
// [RULE8] Each threshold alarm trips above its threshold when high, below it when low.
// [RULE9] Each threshold alarm selects failsafe or nonfailsafe relay drive.
// [RULE10] Each threshold alarm selects latching or nonlatching behaviour.
// [RULE11] A defeated threshold alarm never actuates.
// [RULE12] The system alarm trips on bad supply or failed self test, always failsafe and latching.
// [RULE13] A latched system alarm clears only after power off, power on, then a non-system key.
// [RULE14] The voltage range ID shows low, medium, high, air cal as ascending levels.
// [RULE15] The current range ID encodes the same four ranges ascending, air cal on top.
// [RULE16] A failsafe relay is energised when quiet and released on alarm; nonfailsafe the reverse.
module rcac_top
	import rcac_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Remote calibration
	input wire logic remote_zero,
	input wire logic remote_span,
	output logic cal_busy,
	// Monitors
	input wire logic supply_fault,
	input wire logic self_test_fail,
	// Relays and range ID
	output logic al1_relay,
	output logic al2_relay,
	output logic sys_relay,
	output logic [7:0] range_id_volt,
	output logic [7:0] range_id_curr,
	// Interrupt
	output logic irq
);

	function automatic logic trip(input logic [31:0] cfg, input logic [15:0] conc);
		logic over;
		logic under;
		over = conc > cfg[CFG_THR_W-1:0];
		under = conc < cfg[CFG_THR_W-1:0];
		trip = !cfg[CFG_DEFEAT] && (cfg[CFG_HIGH] ? over : under); // [RULE8] [RULE11]
	endfunction

	function automatic logic relay_drive(input logic [31:0] cfg, input logic active);
		relay_drive = cfg[CFG_FAILSAFE] ? !active : active; // [RULE9] [RULE16]
	endfunction

	logic [31:0] ctrl_q;
	logic [31:0] al1_cfg_q;
	logic [31:0] al2_cfg_q;
	logic [15:0] conc_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_set;
	rcac_cal_t cal_q;
	rcac_sys_t sys_q;
	logic al1_act_q;
	logic al2_act_q;
	logic aw_hold_q;
	logic w_hold_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic wr_fire;
	logic cal_done;
	logic key_pwr;
	logic key_other;
	logic al1_cond;
	logic al2_cond;
	logic [31:0] wdata_m;
	logic [31:0] rd_val;
	logic rd_ok;
	logic [1:0] cmd_prev_q;

	// Write channel capture in either order
	assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

	always_ff @(posedge clk) begin
		if (srst) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_hold_q && !s_axi_awready;
			s_axi_wready <= !w_hold_q && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
					{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q == ADDR_STATUS || awaddr_q > ADDR_CONC ||
					awaddr_q[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
			end
		end
	end

	assign wdata_m = wdata_q;
	assign cal_done = wr_fire && awaddr_q == ADDR_CTRL && wdata_m[CTRL_CAL_DONE];
	assign key_pwr = wr_fire && awaddr_q == ADDR_CTRL && wdata_m[CTRL_KEY_PWR];
	assign key_other = wr_fire && awaddr_q == ADDR_CTRL && wdata_m[CTRL_KEY_OTHER];

	// Configuration registers; pulse bits of ctrl are not stored
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= 32'h0000_0000;
			al1_cfg_q <= CFG_RESET;
			al2_cfg_q <= CFG_RESET;
			conc_q <= 16'h0000;
		end else if (wr_fire) begin
			case (awaddr_q)
				ADDR_CTRL: ctrl_q <= {26'h000_0000, wdata_m[CTRL_RANGE_LO+1:CTRL_RANGE_LO], 4'h0};
				ADDR_AL1_CFG: al1_cfg_q <= {12'h000, wdata_m[19:0]};
				ADDR_AL2_CFG: al2_cfg_q <= {12'h000, wdata_m[19:0]};
				ADDR_CONC: conc_q <= wdata_m[15:0];
				default: ;
			endcase
		end
	end

	// Calibration handshake
	always_ff @(posedge clk) begin
		if (srst) begin
			cal_q <= CAL_IDLE;
		end else begin
			case (cal_q)
				CAL_IDLE: begin
					if (remote_zero) begin // [RULE1] [RULE3]
						cal_q <= CAL_ZERO;
					end else if (remote_span) begin
						cal_q <= CAL_SPAN;
					end
				end
				CAL_ZERO, CAL_SPAN: begin
					// Inputs not looked at here, so requests are lost
					if (cal_done) begin // [RULE4]
						cal_q <= CAL_IDLE; // [RULE6]
					end
				end
				default: cal_q <= CAL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cal_busy <= 1'b0;
		end else begin
			cal_busy <= (cal_q != CAL_IDLE && !cal_done) || (cal_q == CAL_IDLE &&
				(remote_zero || remote_span)); // [RULE2]
		end
	end

	// Threshold alarms
	assign al1_cond = trip(al1_cfg_q, conc_q);
	assign al2_cond = trip(al2_cfg_q, conc_q);

	always_ff @(posedge clk) begin
		if (srst) begin
			al1_act_q <= 1'b0;
			al2_act_q <= 1'b0;
		end else begin
			al1_act_q <= al1_cond ||
				(al1_cfg_q[CFG_LATCH] && al1_act_q && !al1_cfg_q[CFG_DEFEAT]); // [RULE10]
			al2_act_q <= al2_cond ||
				(al2_cfg_q[CFG_LATCH] && al2_act_q && !al2_cfg_q[CFG_DEFEAT]); // [RULE10]
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			al1_relay <= 1'b0;
			al2_relay <= 1'b0;
			sys_relay <= 1'b0;
		end else begin
			al1_relay <= relay_drive(al1_cfg_q, al1_act_q); // [RULE16]
			al2_relay <= relay_drive(al2_cfg_q, al2_act_q); // [RULE16]
			sys_relay <= sys_q == SYS_OK; // [RULE12]
		end
	end

	// System alarm latch and clear sequence
	always_ff @(posedge clk) begin
		if (srst) begin
			sys_q <= SYS_OK;
		end else begin
			case (sys_q)
				SYS_OK: if (supply_fault || self_test_fail) sys_q <= SYS_LATCHED; // [RULE12]
				SYS_LATCHED: if (key_pwr) sys_q <= SYS_PWR_OFF; // [RULE13]
				SYS_PWR_OFF: if (key_pwr) sys_q <= SYS_WAIT_KEY; // [RULE13]
				SYS_WAIT_KEY: if (key_other) sys_q <= SYS_OK; // [RULE13]
				default: sys_q <= SYS_LATCHED;
			endcase
		end
	end

	// Range identification outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			range_id_volt <= VID_LOW;
			range_id_curr <= IID_LOW;
		end else begin
			case (ctrl_q[CTRL_RANGE_LO+1:CTRL_RANGE_LO])
				RANGE_LOW: begin
					range_id_volt <= VID_LOW; // [RULE14]
					range_id_curr <= IID_LOW; // [RULE15]
				end
				RANGE_MED: begin
					range_id_volt <= VID_MED;
					range_id_curr <= IID_MED;
				end
				RANGE_HIGH: begin
					range_id_volt <= VID_HIGH;
					range_id_curr <= IID_HIGH;
				end
				default: begin
					range_id_volt <= VID_AIR;
					range_id_curr <= IID_AIR;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_prev_q <= 2'b00;
		end else begin
			cmd_prev_q <= {remote_span, remote_zero};
		end
	end

	// Interrupt status: set wins over write-one clear
	assign irq_set = {sys_q == SYS_OK && (supply_fault || self_test_fail),
		!al2_act_q && al2_cond, !al1_act_q && al1_cond,
		cal_q != CAL_IDLE && |({remote_span, remote_zero} & ~cmd_prev_q), // [RULE4]
		cal_q != CAL_IDLE && cal_done,
		cal_q == CAL_IDLE && (remote_zero || remote_span)};

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			irq <= 1'b0;
		end else begin
			if (wr_fire && awaddr_q == ADDR_IRQ_STAT) begin
				irq_stat_q <= (irq_stat_q & ~wdata_m[IRQ_W-1:0]) | irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set;
			end
			if (wr_fire && awaddr_q == ADDR_IRQ_MASK) begin
				irq_mask_q <= wdata_m[IRQ_W-1:0];
			end
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Read channel
	always_comb begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			ADDR_CTRL: rd_val = ctrl_q;
			ADDR_STATUS: rd_val = {22'h00_0000, sys_q, al2_act_q, al1_act_q, 2'b00, cal_q,
				cal_busy, 1'b0};
			ADDR_IRQ_STAT: rd_val = {26'h000_0000, irq_stat_q};
			ADDR_IRQ_MASK: rd_val = {26'h000_0000, irq_mask_q};
			ADDR_AL1_CFG: rd_val = al1_cfg_q;
			ADDR_AL2_CFG: rd_val = al2_cfg_q;
			ADDR_CONC: rd_val = {16'h0000, conc_q};
			default: begin
				rd_val = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Checks
	a_busy_follows_start: assert property (@(posedge clk) disable iff (srst) // [RULE1]
		(cal_q == CAL_IDLE && remote_zero) |=> cal_busy && cal_q == CAL_ZERO)
		else $error("zero command did not start calibration");
	a_busy_matches_cal: assert property (@(posedge clk) disable iff (srst) // [RULE2]
		$past(cal_q) != CAL_IDLE && !$past(cal_done) |-> cal_busy)
		else $error("busy open during calibration");
	a_reject_no_memory: assert property (@(posedge clk) disable iff (srst) // [RULE4]
		(cal_q != CAL_IDLE && (remote_zero || remote_span) && !cal_done) |=>
		cal_q == $past(cal_q))
		else $error("request taken during calibration");
	a_defeat_blocks_alarm: assert property (@(posedge clk) disable iff (srst) // [RULE11]
		al1_cfg_q[CFG_DEFEAT] [*2] |-> !al1_act_q)
		else $error("defeated alarm actuated");
	a_sys_latches: assert property (@(posedge clk) disable iff (srst) // [RULE13]
		(sys_q != SYS_OK && !key_pwr && !key_other) |=> sys_q == $past(sys_q))
		else $error("system alarm left latch without keys");
	a_sys_relay_drop: assert property (@(posedge clk) disable iff (srst) // [RULE12]
		(sys_q == SYS_OK && supply_fault) |=> ##1 !sys_relay)
		else $error("system relay not released on fault");
	a_failsafe_drive: assert property (@(posedge clk) disable iff (srst) // [RULE9]
		$stable(al1_cfg_q) && al1_cfg_q[CFG_FAILSAFE] |=> al1_relay == !$past(al1_act_q))
		else $error("failsafe relay wrong level");
	a_range_air_top: assert property (@(posedge clk) disable iff (srst) // [RULE15]
		ctrl_q[CTRL_RANGE_LO+1:CTRL_RANGE_LO] == RANGE_AIR |=> range_id_curr == IID_AIR
		&& range_id_volt == VID_AIR)
		else $error("air range level wrong");

endmodule // rcac_top
